// File: rtl/strap_cfg_pkg.sv
// package of constants for the reset-time strap configuration block
// assumes one clock domain and straps held steady around reset release
package strap_cfg_pkg;
    // -------------------------------------------------------------
    // strap vector layout
    // -------------------------------------------------------------
    localparam int STRAP_W = 9;
    localparam int BIT_P1_PLUS = 0;
    localparam int BIT_P1_MINUS = 1;
    localparam int BIT_P2_PLUS = 2;
    localparam int BIT_P2_MINUS = 3;
    localparam int BIT_SEL_LO = 4;
    localparam int BIT_SEL_HI = 5;
    localparam int BIT_SWAP = 6;
    localparam int BIT_PWR1 = 7;
    localparam int BIT_OCS1_LOW = 8;
    localparam logic [8:0] STRAP_RESET = 9'h000;
    localparam logic STRAP_DISABLED = 1'b1;
    localparam logic [1:0] CFG_METHOD_RESET = 2'h0;
    // -------------------------------------------------------------
    // capture sequencer states
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SYNC = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_HOLD = 2'b11
    } cap_state_t;
    localparam logic [1:0] SYNC_CYCLES = 2'h2;
endpackage : strap_cfg_pkg

// File: rtl/strap_sync.sv
// two-flop synchroniser bank for the strap pins
// assumes pins are asynchronous to mclk
`timescale 1ns/10ps
module strap_sync (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [strap_cfg_pkg::STRAP_W-1:0] pins_in,
    output logic [strap_cfg_pkg::STRAP_W-1:0] pins_sync
);
    import strap_cfg_pkg::*;
    logic [STRAP_W-1:0] meta_ff;
    logic [STRAP_W-1:0] sync_ff;
    // -------------------------------------------------------------
    // synchroniser; first stage feeds only the second
    // -------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < STRAP_W; g++) begin : g_bit
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    meta_ff[g] <= 1'b0;
                    sync_ff[g] <= 1'b0;
                end else if (clk_en) begin
                    meta_ff[g] <= pins_in[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate
    assign pins_sync = sync_ff;
endmodule : strap_sync

// File: rtl/strap_cfg.sv
// strap capture and decode for port disable, role swap and config method
// assumes straps are static while reset is released and a few cycles after
`timescale 1ns/10ps
module strap_cfg (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic port1_plus_disable_strap,
    input wire logic port1_minus_disable_strap,
    input wire logic port2_plus_disable_strap,
    input wire logic port2_minus_disable_strap,
    input wire logic config_method_select_lo,
    input wire logic config_method_select_hi,
    input wire logic role_swap_strap,
    input wire logic port1_power_enable_out,
    input wire logic port1_overcurrent_in_low,
    output logic port1_enabled,
    output logic port2_enabled,
    output logic role_swap_active,
    output logic [1:0] config_method,
    output logic power_ctrl_compat,
    output logic straps_valid
);
    import strap_cfg_pkg::*;
    logic [STRAP_W-1:0] pins_raw;
    logic [STRAP_W-1:0] pins_sync;
    logic [STRAP_W-1:0] strap_ff;
    logic [STRAP_W-1:0] nxt_strap;
    cap_state_t state_ff;
    cap_state_t nxt_state;
    logic [1:0] wait_ff;
    logic [1:0] nxt_wait;
    logic port1_enabled_ff;
    logic port2_enabled_ff;
    logic swap_ff;
    logic [1:0] method_ff;
    logic compat_ff;
    logic valid_ff;
    wire p1_dis;
    wire p2_dis;
    wire capture_now;

    // both straps of a pair must read disabled
    function automatic logic pair_disabled(input logic plus_s, input logic minus_s);
        pair_disabled = (plus_s == STRAP_DISABLED) && (minus_s == STRAP_DISABLED);
    endfunction : pair_disabled

    // -------------------------------------------------------------
    // pin synchronisation
    // -------------------------------------------------------------
    // power pins ride the same two-flop path as the disable straps
    assign pins_raw = {port1_overcurrent_in_low, port1_power_enable_out, role_swap_strap,
                       config_method_select_hi, config_method_select_lo,
                       port2_minus_disable_strap, port2_plus_disable_strap,
                       port1_minus_disable_strap, port1_plus_disable_strap};

    strap_sync u_sync (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .pins_in(pins_raw),
        .pins_sync(pins_sync)
    );

    // -------------------------------------------------------------
    // capture sequencer: wait out the synchroniser, sample once, hold
    // -------------------------------------------------------------
    // decoding from nxt_strap lets the outputs land on the capture edge itself
    // and saves a cycle against decoding the held image
    assign capture_now = (state_ff == ST_CAPTURE);
    assign nxt_strap = capture_now ? pins_sync : strap_ff;

    // wait count covers both synchroniser stages before the sample is taken
    // an illegal code restarts the sequence rather than latching junk
    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        unique case (state_ff)
            ST_SYNC: begin
                nxt_wait = wait_ff + 2'h1;
                if (wait_ff == SYNC_CYCLES - 2'h1) begin
                    nxt_state = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                nxt_state = ST_HOLD;
            end
            ST_HOLD: begin
                nxt_state = ST_HOLD;
            end
            default: begin
                nxt_state = ST_SYNC;
            end
        endcase
    end

    // sequencer and held strap image
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_SYNC;
            wait_ff <= 2'h0;
            strap_ff <= STRAP_RESET;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            strap_ff <= nxt_strap;
        end
    end

    // -------------------------------------------------------------
    // decode of the next strap image, nxt_strap
    // -------------------------------------------------------------
    // a 1 on a strap means that line is disabled, 0 enabled
    assign p1_dis = pair_disabled(nxt_strap[BIT_P1_PLUS], nxt_strap[BIT_P1_MINUS]);
    assign p2_dis = pair_disabled(nxt_strap[BIT_P2_PLUS], nxt_strap[BIT_P2_MINUS]);

    // limitation: a strap that moves inside the sync window is taken as seen
    // later pin activity cannot reach these flops, only a new reset can
    // outputs registered; ports stay enabled until the capture lands
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            port1_enabled_ff <= 1'b1;
            port2_enabled_ff <= 1'b1;
            swap_ff <= 1'b0;
            method_ff <= CFG_METHOD_RESET;
            compat_ff <= 1'b0;
            valid_ff <= 1'b0;
        end else if (clk_en) begin
            port1_enabled_ff <= !p1_dis;
            port2_enabled_ff <= !p2_dis;
            swap_ff <= nxt_strap[BIT_SWAP];
            method_ff <= {nxt_strap[BIT_SEL_HI], nxt_strap[BIT_SEL_LO]};
            // overcurrent is active low: high means no fault, as compat needs
            compat_ff <= nxt_strap[BIT_PWR1] && nxt_strap[BIT_OCS1_LOW];
            valid_ff <= capture_now || valid_ff;
        end
    end

    // ports come straight from the flops, no gate after them
    assign port1_enabled = port1_enabled_ff;
    assign port2_enabled = port2_enabled_ff;
    assign role_swap_active = swap_ff;
    assign config_method = method_ff;
    assign power_ctrl_compat = compat_ff;
    assign straps_valid = valid_ff;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    // decode checks compare each output with the held image
    chk_p1_pair_decode: assert property (@(posedge mclk) disable iff (reset)
        clk_en && valid_ff |-> port1_enabled ==
        !(strap_ff[BIT_P1_PLUS] && strap_ff[BIT_P1_MINUS]))
        else $error("port 1 enable does not match straps");
    chk_p1_plus_only: assert property (@(posedge mclk) disable iff (reset)
        valid_ff && strap_ff[BIT_P1_PLUS] && !strap_ff[BIT_P1_MINUS] |-> port1_enabled)
        else $error("port 1 disabled by plus strap alone");
    chk_p1_minus_only: assert property (@(posedge mclk) disable iff (reset)
        valid_ff && !strap_ff[BIT_P1_PLUS] && strap_ff[BIT_P1_MINUS] |-> port1_enabled)
        else $error("port 1 disabled by minus strap alone");
    chk_p2_pair_decode: assert property (@(posedge mclk) disable iff (reset)
        clk_en && valid_ff |-> port2_enabled ==
        !(strap_ff[BIT_P2_PLUS] && strap_ff[BIT_P2_MINUS]))
        else $error("port 2 enable does not match straps");
    chk_p2_single_strap: assert property (@(posedge mclk) disable iff (reset)
        valid_ff && (strap_ff[BIT_P2_PLUS] != strap_ff[BIT_P2_MINUS]) |-> port2_enabled)
        else $error("port 2 disabled by single strap");
    chk_swap_follows: assert property (@(posedge mclk) disable iff (reset)
        valid_ff |-> role_swap_active == strap_ff[BIT_SWAP])
        else $error("role swap differs from captured strap");
    chk_method_code: assert property (@(posedge mclk) disable iff (reset)
        valid_ff |-> config_method == {strap_ff[BIT_SEL_HI], strap_ff[BIT_SEL_LO]})
        else $error("config method differs from straps");
    chk_compat_level: assert property (@(posedge mclk) disable iff (reset)
        valid_ff |-> power_ctrl_compat == (strap_ff[BIT_PWR1] && strap_ff[BIT_OCS1_LOW]))
        else $error("compat flag wrong polarity");
    chk_hold_stable: assert property (@(posedge mclk) disable iff (reset)
        valid_ff |=> $stable(strap_ff) && valid_ff)
        else $error("captured straps changed after capture");
    chk_valid_timing: assert property (@(posedge mclk) disable iff (reset)
        $rose(valid_ff) |-> $past(state_ff) == ST_CAPTURE)
        else $error("valid rose without capture");

    // -------------------------------------------------------------
    // checks on the capture sequence and the hold
    // -------------------------------------------------------------
    // before the capture lands every output shows its reset value
    chk_idle_defaults: assert property (@(posedge mclk) disable iff (reset)
        !valid_ff |-> port1_enabled && port2_enabled && !role_swap_active &&
        config_method == CFG_METHOD_RESET && !power_ctrl_compat)
        else $error("outputs moved before capture");
    chk_p1_both_high: assert property (@(posedge mclk) disable iff (reset)
        valid_ff && strap_ff[BIT_P1_PLUS] && strap_ff[BIT_P1_MINUS] |-> !port1_enabled)
        else $error("port 1 enabled with both straps high");
    chk_p2_both_high: assert property (@(posedge mclk) disable iff (reset)
        valid_ff && strap_ff[BIT_P2_PLUS] && strap_ff[BIT_P2_MINUS] |-> !port2_enabled)
        else $error("port 2 enabled with both straps high");
    // pins may toggle after capture; none of the outputs may follow
    chk_outputs_hold: assert property (@(posedge mclk) disable iff (reset)
        valid_ff |=> $stable(port1_enabled) && $stable(port2_enabled) &&
        $stable(role_swap_active) && $stable(config_method) &&
        $stable(power_ctrl_compat))
        else $error("outputs changed after capture");
    chk_capture_image: assert property (@(posedge mclk) disable iff (reset)
        clk_en && capture_now |=> strap_ff == $past(pins_sync))
        else $error("held image differs from synchronised pins");
    chk_capture_once: assert property (@(posedge mclk) disable iff (reset)
        clk_en && capture_now |=> !capture_now)
        else $error("capture repeated");
    chk_sync_wait: assert property (@(posedge mclk) disable iff (reset)
        $rose(capture_now) |-> $past(wait_ff) == SYNC_CYCLES - 2'h1)
        else $error("capture before synchroniser settled");
    chk_valid_in_hold: assert property (@(posedge mclk) disable iff (reset)
        valid_ff |-> state_ff == ST_HOLD)
        else $error("valid set outside the hold state");
    // main scenarios: each port off, swap, top method code, compat
    cov_p1_off: cover property (@(posedge mclk) disable iff (reset) valid_ff && !port1_enabled);
    cov_p2_off: cover property (@(posedge mclk) disable iff (reset) valid_ff && !port2_enabled);
    cov_swap_on: cover property (@(posedge mclk) disable iff (reset) valid_ff && role_swap_active);
    cov_method3: cover property (@(posedge mclk) disable iff (reset) config_method == 2'h3);
    cov_compat_on: cover property (@(posedge mclk) disable iff (reset) valid_ff && power_ctrl_compat);
endmodule : strap_cfg

// File: dv/strap_board_model.sv
// board model: strap resistors plus the port-1 power controller pins
// assumes the bench picks the strap word while reset is asserted
`timescale 1ns/10ps
module strap_board_model (
    input wire logic [8:0] strap_word,
    input wire logic scramble,
    output logic [8:0] pins
);
    // ---------------------------------------------------------------
    // pin levels
    // ---------------------------------------------------------------
    // after capture the pins flip, so a late or repeated capture
    // shows up as the inverse instead of a lucky match
    // power-enable and overcurrent (active low) sit high in compat words
    assign pins = scramble ? ~strap_word : strap_word;
endmodule : strap_board_model

// File: dv/tb_strap_cfg.sv
// self-checking bench for the strap capture and decode block
// assumes one 50 MHz clock and the board model on every strap pin
`timescale 1ns/10ps
module tb_strap_cfg;
    import strap_cfg_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic scramble = 1'b0;
    logic [8:0] word = 9'h000;
    logic [8:0] pins;
    logic p1_en, p2_en, swap, compat, valid;
    logic [1:0] method;
    logic [5:0] got;
    int num_errors = 0;
    int n_tests = 0;
    // single straps, pairs, every select code, swap and compat combos
    logic [8:0] cases [14] = '{9'h003, 9'h001, 9'h002, 9'h00c, 9'h004, 9'h008,
        9'h000, 9'h010, 9'h020, 9'h030, 9'h040, 9'h180, 9'h080, 9'h1ff};
    // ---------------------------------------------------------------
    // clock, board and design
    // ---------------------------------------------------------------
    always #10 mclk = ~mclk;
    strap_board_model i_strap_board_model (.strap_word(word), .scramble(scramble),
        .pins(pins));
    strap_cfg i_strap_cfg (.mclk(mclk), .reset(reset), .clk_en(clk_en),
        .port1_plus_disable_strap(pins[BIT_P1_PLUS]),
        .port1_minus_disable_strap(pins[BIT_P1_MINUS]),
        .port2_plus_disable_strap(pins[BIT_P2_PLUS]),
        .port2_minus_disable_strap(pins[BIT_P2_MINUS]),
        .config_method_select_lo(pins[BIT_SEL_LO]),
        .config_method_select_hi(pins[BIT_SEL_HI]),
        .role_swap_strap(pins[BIT_SWAP]), .port1_power_enable_out(pins[BIT_PWR1]),
        .port1_overcurrent_in_low(pins[BIT_OCS1_LOW]), .port1_enabled(p1_en),
        .port2_enabled(p2_en), .role_swap_active(swap), .config_method(method),
        .power_ctrl_compat(compat), .straps_valid(valid));
    assign got = {p1_en, p2_en, swap, method, compat};
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // port off only when both of its straps read high
    function automatic logic [5:0] expect_of(input logic [8:0] w);
        return {~(w[0] & w[1]), ~(w[2] & w[3]), w[6], w[5], w[4], w[7] & w[8]};
    endfunction : expect_of
    task automatic check(input logic [5:0] obs, input logic [5:0] exp);
        n_tests++;
        if (obs !== exp) begin
            num_errors++;
            $display("[ERR] %0t saw %h expected %h", $time, obs, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    // one reset per strap word; pins flip after capture to prove the hold
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        for (int k = 0; k < 14; k++) begin
            reset = 1'b1;
            scramble = 1'b0;
            word = cases[k];
            @(posedge mclk);
            #1;
            check(got, 6'h30);
            check({5'h00, valid}, 6'h00);
            reset = 1'b0;
            if (k == 0) begin
                // frozen enable must stall the whole capture sequence
                clk_en = 1'b0;
                repeat (5) @(posedge mclk);
                #1;
                check({5'h00, valid}, 6'h00);
                clk_en = 1'b1;
            end
            repeat (2) @(posedge mclk);
            #1;
            check({5'h00, valid}, 6'h00);
            @(posedge mclk);
            #1;
            check({5'h00, valid}, 6'h01);
            check(got, expect_of(cases[k]));
            scramble = 1'b1;
            repeat (4) @(posedge mclk);
            #1;
            check(got, expect_of(cases[k]));
        end
        wrap_up();
    end
    // watchdog: the tests need about 140 cycles, allow 2000
    initial begin
        #40000;
        num_errors++;
        wrap_up();
    end
endmodule : tb_strap_cfg
